// >>> rtl/bpos_steer.v
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "bpos_map.vh"

// Notes on behaviour
// - half-bridge drives pwm on a, complement b
// - seven-bit count delays activation, instruction cycles
// - delay beyond active time keeps output inactive
// - delay only on inactive-to-active edges
// - full-bridge uses four outputs, two active
// - forward: a active, d modulated, b c off
// - reverse: c active, b modulated, a d off
// - new direction applies from next pwm cycle
// - swap actives one timer tick before period
// - modulated outputs inactive until next period
// - prescale 1, 4 or 16 from select field
// - full-bridge applies no dead-band delay
// - two-bit field picks one of four arrangements
// - period ends tick after timer equals limit
// - duty, config field and polarity double-buffered; delay at duty or period
// - polarity selects active level of all outputs
module bpos_steer #(
    parameter CLK_PER_TOSC = `BPOS_CLK_PER_TOSC
) (
    // clock and reset
    input wire i_clock,
    input wire i_sys_rst,
    // register port
    input wire [3:0] i_addr,
    input wire [9:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [9:0] o_rdata,
    // bridge outputs
    output reg o_bridge_out_a,
    output reg o_bridge_out_b,
    output reg o_bridge_out_c,
    output reg o_bridge_out_d,
    // timing status
    output reg o_period_start
);

    // ************************************************************
    // software registers
    // ************************************************************
    reg [7:0] pwm_control_reg;
    reg [6:0] deadband_delay_reg;
    reg [7:0] period_limit_reg;
    reg [9:0] duty_reg;

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            pwm_control_reg <= `BPOS_CTRL_RST;
            deadband_delay_reg <= `BPOS_DELAY_RST;
            period_limit_reg <= `BPOS_PERIOD_RST;
            duty_reg <= `BPOS_DUTY_RST;
        end else if (i_wr) begin
            if (i_addr == `BPOS_ADDR_CTRL) begin
                pwm_control_reg <= i_wdata[7:0];
            end else if (i_addr == `BPOS_ADDR_DELAY) begin
                deadband_delay_reg <= i_wdata[6:0];
            end else if (i_addr == `BPOS_ADDR_PERIOD) begin
                period_limit_reg <= i_wdata[7:0];
            end else if (i_addr == `BPOS_ADDR_DUTY) begin
                duty_reg <= i_wdata;
            end
        end
    end

    wire enable = pwm_control_reg[`BPOS_CTRL_ENABLE];

    // ************************************************************
    // prescaled timer ticks
    // ************************************************************
    wire tosc_tick;
    wire timer_tick;

    bpos_prescale #(
        .CLK_PER_TOSC(CLK_PER_TOSC)
    ) u_prescale (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_run(enable),
        .i_ps_sel(pwm_control_reg[`BPOS_CTRL_PS_HI:`BPOS_CTRL_PS_LO]),
        .o_tosc_tick(tosc_tick),
        .o_timer_tick(timer_tick)
    );

    // ************************************************************
    // period timer and double buffers
    // ************************************************************
    reg [7:0] period_timer_count;
    reg [1:0] q_phase;
    reg [9:0] duty_act;
    reg [1:0] output_config_field;
    reg pol_low;
    reg [6:0] deadband_count;
    reg loaded;
    reg swapped;

    // full 10-bit time base: timer count and two tosc phase bits
    wire [9:0] fine_time = {period_timer_count, q_phase};
    wire at_limit = (period_timer_count == period_limit_reg);
    wire period_end = timer_tick && at_limit;
    wire [1:0] cfg_req =
        pwm_control_reg[`BPOS_CTRL_CFG_HI:`BPOS_CTRL_CFG_LO];
    // full-bridge codes share their low bit; direction sits above it
    function is_full_bridge;
        input [1:0] cfg;
        begin
            is_full_bridge = cfg[0];
        end
    endfunction

    wire full_now = is_full_bridge(output_config_field);
    wire dir_change = full_now && is_full_bridge(cfg_req) &&
        (cfg_req[1] != output_config_field[1]);
    // last timer tick of the period: the swap window begins
    wire last_tick = timer_tick &&
        (period_timer_count == period_limit_reg - 8'h01);
    wire duty_hit = (fine_time >= duty_act);

    always @(posedge i_clock) begin
        if (i_sys_rst || !enable) begin
            period_timer_count <= 8'h00;
            q_phase <= 2'h0;
            duty_act <= `BPOS_DUTY_RST;
            output_config_field <= `BPOS_CFG_SINGLE;
            pol_low <= 1'b0;
            deadband_count <= `BPOS_DELAY_RST;
            loaded <= 1'b0;
            swapped <= 1'b0;
            o_period_start <= 1'b0;
        end else begin
            o_period_start <= period_end;
            if (tosc_tick) begin
                q_phase <= q_phase + 2'h1;
            end
            if (period_end) begin
                period_timer_count <= 8'h00;
                q_phase <= 2'h0;
                duty_act <= duty_reg;
                output_config_field <= cfg_req;
                pol_low <= pwm_control_reg[`BPOS_CTRL_POL];
                deadband_count <= deadband_delay_reg;
                loaded <= 1'b1;
                swapped <= 1'b0;
            end else if (timer_tick) begin
                period_timer_count <= period_timer_count + 8'h01;
                if (last_tick && dir_change) begin
                    swapped <= 1'b1;
                end
            end
            if (!period_end && loaded && duty_hit) begin
                deadband_count <= deadband_delay_reg;
            end
        end
    end

    // ************************************************************
    // modulated signal and dead-band
    // ************************************************************
    reg pwm_raw;
    // dead-band is counted in tosc ticks, four to an instruction cycle
    wire [8:0] dly_limit = {deadband_count, 2'h0};
    wire [1:0] leg_want = {!pwm_raw, pwm_raw};
    wire [1:0] leg_on;

    // set one clock after the boundary, as the clear lands one clock
    // after its match: the high time is then exactly the duty value
    always @(posedge i_clock) begin
        if (i_sys_rst || !enable) begin
            pwm_raw <= 1'b0;
        end else if (o_period_start) begin
            pwm_raw <= (duty_act != 10'h000);
        end else if (duty_hit && tosc_tick) begin
            pwm_raw <= 1'b0;
        end
    end

    // each leg counts from the clock it turns wanted, so turn-off is
    // immediate and only turn-on waits; a phase-aligned cycle tick
    // would cut the first instruction cycle of the delay short
    genvar leg;
    generate
        for (leg = 0; leg < 2; leg = leg + 1) begin : g_leg
            reg [8:0] dly;

            always @(posedge i_clock) begin
                if (i_sys_rst || !enable) begin
                    dly <= 9'h000;
                end else if (!leg_want[leg]) begin
                    dly <= 9'h000;
                end else if (tosc_tick && (dly < dly_limit)) begin
                    dly <= dly + 9'h001;
                end
            end

            // a count beyond the active time never completes: stays off
            assign leg_on[leg] = leg_want[leg] &&
                (dly >= dly_limit);
        end
    endgenerate

    wire half_a = leg_on[0];
    wire half_b = leg_on[1] && loaded;

    // ************************************************************
    // steering
    // ************************************************************
    reg next_a;
    reg next_b;
    reg next_c;
    reg next_d;

    always @* begin
        next_a = 1'b0;
        next_b = 1'b0;
        next_c = 1'b0;
        next_d = 1'b0;
        if (loaded) begin
            case (output_config_field)
                `BPOS_CFG_SINGLE: begin
                    next_a = pwm_raw;
                end
                `BPOS_CFG_HALF: begin
                    next_a = half_a;
                    next_b = half_b;
                end
                `BPOS_CFG_FWD: begin
                    // no dead-band in either full-bridge direction
                    next_a = !swapped;
                    next_c = swapped;
                    next_d = pwm_raw && !swapped;
                end
                default: begin
                    next_c = !swapped;
                    next_a = swapped;
                    next_b = pwm_raw && !swapped;
                end
            endcase
        end
    end

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_bridge_out_a <= 1'b0;
            o_bridge_out_b <= 1'b0;
            o_bridge_out_c <= 1'b0;
            o_bridge_out_d <= 1'b0;
        end else begin
            o_bridge_out_a <= next_a ^ pol_low;
            o_bridge_out_b <= next_b ^ pol_low;
            o_bridge_out_c <= next_c ^ pol_low;
            o_bridge_out_d <= next_d ^ pol_low;
        end
    end

    // ************************************************************
    // register read
    // ************************************************************
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= 10'h000;
        end else if (i_rd) begin
            if (i_addr == `BPOS_ADDR_CTRL) begin
                o_rdata <= {2'h0, pwm_control_reg};
            end else if (i_addr == `BPOS_ADDR_DELAY) begin
                o_rdata <= {3'h0, deadband_delay_reg};
            end else if (i_addr == `BPOS_ADDR_PERIOD) begin
                o_rdata <= {2'h0, period_limit_reg};
            end else if (i_addr == `BPOS_ADDR_DUTY) begin
                o_rdata <= duty_reg;
            end else if (i_addr == `BPOS_ADDR_STATUS) begin
                o_rdata <= {swapped, loaded, period_timer_count};
            end else begin
                o_rdata <= 10'h000;
            end
        end else begin
            o_rdata <= 10'h000;
        end
    end

endmodule

// >>> rtl/bpos_map.vh
`ifndef BPOS_MAP_VH
`define BPOS_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define BPOS_ADDR_CTRL 4'h0
`define BPOS_ADDR_DELAY 4'h1
`define BPOS_ADDR_PERIOD 4'h2
`define BPOS_ADDR_DUTY 4'h3
`define BPOS_ADDR_STATUS 4'h4

// ************************************************************
// control field positions
// ************************************************************
`define BPOS_CTRL_ENABLE 0
`define BPOS_CTRL_POL 1
`define BPOS_CTRL_CFG_LO 2
`define BPOS_CTRL_CFG_HI 3
`define BPOS_CTRL_PS_LO 4
`define BPOS_CTRL_PS_HI 5

// ************************************************************
// output configuration codes
// ************************************************************
`define BPOS_CFG_SINGLE 2'h0
`define BPOS_CFG_FWD 2'h1
`define BPOS_CFG_HALF 2'h2
`define BPOS_CFG_REV 2'h3

// ************************************************************
// reset values and timing
// ************************************************************
`define BPOS_CTRL_RST 8'h00
`define BPOS_DELAY_RST 7'h00
`define BPOS_PERIOD_RST 8'hFF
`define BPOS_DUTY_RST 10'h000
`define BPOS_TOSC_PER_CYCLE 4
`define BPOS_CLK_PER_TOSC 1

`endif

// >>> rtl/bpos_prescale.v
`timescale 1ns/1ns

// ************************************************************
// timer tick divider: 4 tosc times prescale 1, 4 or 16
// ************************************************************
module bpos_prescale #(
    parameter CLK_PER_TOSC = 1
) (
    // clock and reset
    input wire i_clock,
    input wire i_sys_rst,
    // control
    input wire i_run,
    input wire [1:0] i_ps_sel,
    // enables
    output reg o_tosc_tick,
    output reg o_timer_tick
);

    // 4 tosc x 16 x clocks per tosc fits easily in 16 bits
    reg [15:0] tosc_cnt;
    reg [5:0] q_cnt;
    reg [5:0] q_last;

    // last tosc count, cut to the counter width on purpose
    localparam integer TOSC_LAST_I = CLK_PER_TOSC - 1;
    localparam [15:0] TOSC_LAST = TOSC_LAST_I[15:0];

    always @* begin
        if (i_ps_sel == 2'h0) begin
            q_last = 6'h03;
        end else if (i_ps_sel == 2'h1) begin
            q_last = 6'h0F;
        end else begin
            q_last = 6'h3F;
        end
    end

    always @(posedge i_clock) begin
        if (i_sys_rst || !i_run) begin
            tosc_cnt <= 16'h0000;
            q_cnt <= 6'h00;
            o_tosc_tick <= 1'b0;
            o_timer_tick <= 1'b0;
        end else begin
            o_timer_tick <= 1'b0;
            if (tosc_cnt == TOSC_LAST) begin
                tosc_cnt <= 16'h0000;
                o_tosc_tick <= 1'b1;
                if (q_cnt >= q_last) begin
                    q_cnt <= 6'h00;
                    o_timer_tick <= 1'b1;
                end else begin
                    q_cnt <= q_cnt + 6'h01;
                end
            end else begin
                tosc_cnt <= tosc_cnt + 16'h0001;
                o_tosc_tick <= 1'b0;
            end
        end
    end

endmodule

// >>> dv/bpos_steer_properties.sv
`timescale 1ns/1ns
`include "bpos_map.vh"
module bpos_steer_chk (
    // clock and reset
    input wire i_clock,
    input wire i_sys_rst,
    // register port
    input wire [3:0] i_addr,
    input wire [9:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [9:0] o_rdata,
    // bridge outputs and period start
    input wire o_bridge_out_a,
    input wire o_bridge_out_b,
    input wire o_bridge_out_c,
    input wire o_bridge_out_d,
    input wire o_period_start
);
    // ****
    // shadow control, live from each period start
    // ****
    reg [9:0] ctl;
    reg [9:0] ctl_q;
    reg [9:0] held;
    // outputs follow one clock after the start pulse, with the value
    // the control register had at the boundary itself
    wire [9:0] live = held;
    wire en = live[0];
    wire [1:0] cfg = live[3:2];
    wire fb = en && cfg[0];
    wire [3:0] act = {o_bridge_out_a, o_bridge_out_b, o_bridge_out_c,
        o_bridge_out_d} ^ {4{live[1]}};
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            ctl <= 10'h000;
            ctl_q <= 10'h000;
            held <= 10'h000;
        end else begin
            if (i_wr && i_addr == `BPOS_ADDR_CTRL) begin
                ctl <= i_wdata;
            end
            ctl_q <= ctl;
            if (o_period_start) begin
                held <= ctl_q;
            end
        end
    end
    // ****
    // properties
    // ****
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    property p_rst;
        $fell(i_sys_rst) |-> {act, o_period_start} == 5'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    property p_rdata;
        !$past(i_rd) |-> o_rdata == 10'h000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data not idle");
    property p_pulse;
        o_period_start |=> !o_period_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("period pulse");
    property p_half;
        en && cfg == `BPOS_CFG_HALF |-> !(act[3] && act[2]);
    endproperty
    a_half: assert property (p_half) else $error("half overlap");
    property p_fb;
        fb |-> !(act[2] && act[0]) && !(act[3] && act[1]);
    endproperty
    a_fb: assert property (p_fb) else $error("bridge pair overlap");
    property p_fwd;
        fb && cfg == `BPOS_CFG_FWD && ctl[3:2] == cfg
            |-> act[3] && !act[2] && !act[1];
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward levels");
    property p_rev;
        fb && cfg == `BPOS_CFG_REV && ctl[3:2] == cfg
            |-> act[1] && !act[3] && !act[0];
    endproperty
    a_rev: assert property (p_rev) else $error("reverse levels");
    property p_swap;
        fb && cfg == `BPOS_CFG_FWD && $rose(act[1])
            |-> (!act[3] && !act[0]) throughout (##[1:70] o_period_start);
    endproperty
    a_swap: assert property (p_swap) else $error("swap window");
endmodule
bind bpos_steer bpos_steer_chk u_chk (.i_clock, .i_sys_rst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_bridge_out_a, .o_bridge_out_b,
    .o_bridge_out_c, .o_bridge_out_d, .o_period_start);

// >>> dv/bpos_gate_model.sv
`timescale 1ns/1ns
// ****
// two legs: a over b, c over d; counts shoot-through
// ****
module bpos_gate_model (
    // clock and gates
    input wire i_clock,
    input wire i_pol,
    input wire [3:0] i_gate,
    // overlap cycles
    output reg [15:0] o_shoot
);
    wire [3:0] on = i_gate ^ {4{i_pol}};
    initial o_shoot = 16'h0000;
    // pins taken as driven outputs by firmware
    always @(posedge i_clock) begin
        if ((on[3] && on[2]) || (on[1] && on[0])) begin
            o_shoot <= o_shoot + 16'h0001;
        end
    end
endmodule

// >>> dv/test_bridge_pwm_output_steering.sv
`timescale 1ns/1ns
`include "bpos_map.vh"
module test_bridge_pwm_output_steering;
    reg i_clock = 1'b0;
    reg i_sys_rst = 1'b1;
    reg [3:0] i_addr = 4'h0;
    reg [9:0] i_wdata = 10'h000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    wire [9:0] o_rdata;
    wire [3:0] gate;
    wire o_period_start;
    wire [15:0] shoot;
    reg pol_set = 1'b0;
    reg pol_held = 1'b0;
    // polarity turns one clock after a period start, as the outputs do
    wire pol = pol_held;
    integer n_fail = 0;
    integer n_checks = 0;
    integer ps;
    integer f;
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        if (o_period_start) begin
            pol_held <= pol_set;
        end
    end
    bpos_steer u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_bridge_out_a(gate[3]),
        .o_bridge_out_b(gate[2]), .o_bridge_out_c(gate[1]),
        .o_bridge_out_d(gate[0]), .o_period_start(o_period_start));
    bpos_gate_model u_gate (.i_clock(i_clock), .i_pol(pol),
        .i_gate(gate), .o_shoot(shoot));
    // ****
    // tasks
    // ****
    task check(input [63:0] what, input [15:0] exp, input [15:0] seen);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [9:0] d);
        begin
            @(posedge i_clock);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_clock);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [9:0] exp);
        begin
            @(posedge i_clock);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clock);
            i_rd <= 1'b0;
            #1;
            check("rdata", {6'h00, exp}, {6'h00, o_rdata});
        end
    endtask
    task wait_ps;
        integer k;
        begin
            k = 0;
            @(posedge i_clock) #1;
            while (o_period_start !== 1'b1 && k < 4000) begin
                @(posedge i_clock) #1;
                k = k + 1;
            end
            if (k >= 4000) begin
                check("timeout", 16'h0000, 16'h0001);
            end
        end
    endtask
    // active cycles of a..d over one whole settled period
    task measure(input [15:0] len, input [15:0] ea, input [15:0] eb,
        input [15:0] ec, input [15:0] ed);
        integer n;
        integer i;
        reg [15:0] c [0:3];
        begin
            wait_ps;
            wait_ps;
            n = 0;
            for (i = 0; i < 4; i = i + 1) begin
                c[i] = 16'h0000;
            end
            while (n == 0 || (o_period_start !== 1'b1 && n < 4000)) begin
                for (i = 0; i < 4; i = i + 1) begin
                    c[i] = c[i] + ((gate[3 - i] ^ pol) ? 16'h0001 : 16'h0000);
                end
                n = n + 1;
                @(posedge i_clock) #1;
            end
            check("len", len, n[15:0]);
            check("a", ea, c[0]);
            check("b", eb, c[1]);
            check("c", ec, c[2]);
            check("d", ed, c[3]);
        end
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (16) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rd(`BPOS_ADDR_CTRL, 10'h000);
        rd(`BPOS_ADDR_PERIOD, 10'h0FF);
        rd(4'hF, 10'h000);
        wr(`BPOS_ADDR_PERIOD, 10'h00F);
        wr(`BPOS_ADDR_DUTY, 10'h014);
        wr(`BPOS_ADDR_DELAY, 10'h002);
        rd(`BPOS_ADDR_PERIOD, 10'h00F);
        rd(`BPOS_ADDR_DUTY, 10'h014);
        rd(`BPOS_ADDR_DELAY, 10'h002);
        wr(`BPOS_ADDR_CTRL, 10'h001);
        measure(16'd64, 16'd20, 16'd0, 16'd0, 16'd0);
        rd(`BPOS_ADDR_STATUS, 10'h100);
        wr(`BPOS_ADDR_CTRL, 10'h009);
        measure(16'd64, 16'd12, 16'd36, 16'd0, 16'd0);
        wr(`BPOS_ADDR_DELAY, 10'h006);
        measure(16'd64, 16'd0, 16'd20, 16'd0, 16'd0);
        for (ps = 0; ps < 4; ps = ps + 1) begin
            f = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            wr(`BPOS_ADDR_CTRL, 10'(ps * 16 + 5));
            measure(16'(64 * f), 16'(64 * f), 16'd0, 16'd0,
                16'(20 * f));
        end
        wr(`BPOS_ADDR_CTRL, 10'h005);
        measure(16'd64, 16'd64, 16'd0, 16'd0, 16'd20);
        // duty kept low ahead of the reversal
        wr(`BPOS_ADDR_CTRL, 10'h00F);
        pol_set <= 1'b1;
        measure(16'd64, 16'd0, 16'd20, 16'd64, 16'd0);
        wr(`BPOS_ADDR_CTRL, 10'h007);
        measure(16'd64, 16'd64, 16'd0, 16'd0, 16'd20);
        check("shoot", 16'h0000, shoot);
        summarize;
    end
    initial begin
        #200000;
        check("watchdog", 16'h0000, 16'h0001);
        summarize;
    end
endmodule
